/* File: nco_pkg.sv */
package nco_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [5:0] OFF_CONTROL = 6'h00;
    localparam logic [5:0] OFF_CLOCK_SEL = 6'h04;
    localparam logic [5:0] OFF_ACC_LOW = 6'h08;
    localparam logic [5:0] OFF_ACC_HIGH = 6'h0C;
    localparam logic [5:0] OFF_ACC_UPPER = 6'h10;
    localparam logic [5:0] OFF_STEP_LOW = 6'h14;
    localparam logic [5:0] OFF_STEP_HIGH = 6'h18;
    localparam logic [5:0] OFF_STEP_UPPER = 6'h1C;
    localparam logic [5:0] OFF_STATUS = 6'h20;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTL_ENABLE_POS = 7;
    localparam int CTL_LEVEL_POS = 5;
    localparam int CTL_INVERT_POS = 4;
    localparam int CTL_PULSE_MODE_POS = 0;
    localparam int CLK_WIDTH_LSB = 5;
    localparam int CLK_SOURCE_LSB = 0;
    localparam int STAT_FLAG_POS = 0;

    // ************************************************************
    // reset values and sizes
    // ************************************************************
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_CLOCK_SEL = 8'h00;
    localparam logic [19:0] RST_ACC = 20'h00000;
    localparam logic [19:0] RST_STEP = 20'h00001;
    localparam int ACC_W = 20;
    localparam int NUM_SRC = 6;

    // clock source codes
    localparam logic [2:0] SRC_SYSTEM = 3'h0;
    localparam logic [2:0] SRC_FAST = 3'h1;
    localparam logic [2:0] SRC_CELL_FIRST = 3'h2;
    localparam logic [2:0] SRC_CELL_LAST = 3'h5;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;

endpackage

/* File: nco_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for one asynchronous level
module nco_sync
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* File: nco_top.sv */
`timescale 1ns/1ps
module nco_top
    import nco_pkg::*;
#(
    parameter int ADDR_W = 6
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic clk_src_system,
    input wire logic clk_src_fast,
    input wire logic [3:0] clk_src_cell,
    output logic osc_out,
    output logic overflow_flag
);
    // ************************************************************
    // declarations
    // ************************************************************
    wr_state_t wr_state_q;
    logic aw_have_q, w_have_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic w_lane_q;
    logic wr_go;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_hit;
    logic rd_hit;
    logic [7:0] rd_byte;
    logic module_enable_bit_q, output_invert_bit_q, pulse_mode_select_bit_q;
    logic [2:0] pulse_width_field_q, clock_source_field_q;
    logic [19:0] phase_accumulator_q;
    logic [19:0] step_value_q;
    logic [19:0] step_working_buffer_q;
    logic step_load_pend_q;
    logic [NUM_SRC-1:0] src_raw, src_sync;
    logic sel_clk, sel_clk_prev_q;
    logic clk_rise, clk_fall;
    logic [20:0] acc_sum;
    logic acc_overflow;
    logic acc_wr;
    logic toggle_level_q;
    logic pulse_pend_q, pulse_active_q;
    logic [7:0] pulse_left_q;
    logic raw_level;

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    assign wr_go = aw_have_q && w_have_q && (wr_state_q == WR_IDLE);
    assign wr_addr = aw_addr_q;
    assign wr_byte = w_data_q[7:0];

    // collect address and data in either order, then answer once
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_state_q <= WR_IDLE;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h00000000;
            w_lane_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && !aw_have_q && !s_axi_awready)
            begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_q && !s_axi_wready)
            begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_lane_q <= s_axi_wstrb[0];
            end
            case (wr_state_q)
                WR_IDLE:
                begin
                    if (wr_go)
                    begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                        wr_state_q <= WR_RESP;
                    end
                end
                WR_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        aw_have_q <= 1'b0;
                        w_have_q <= 1'b0;
                        wr_state_q <= WR_IDLE;
                    end
                end
                default:
                begin
                    wr_state_q <= WR_IDLE;
                end
            endcase
        end
    end

    // address decode for writes
    always_comb
    begin
        case (wr_addr)
            OFF_CONTROL, OFF_CLOCK_SEL, OFF_ACC_LOW, OFF_ACC_HIGH, OFF_ACC_UPPER,
            OFF_STEP_LOW, OFF_STEP_HIGH, OFF_STEP_UPPER, OFF_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // ************************************************************
    // control registers
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            module_enable_bit_q <= RST_CONTROL[CTL_ENABLE_POS];
            output_invert_bit_q <= RST_CONTROL[CTL_INVERT_POS];
            pulse_mode_select_bit_q <= RST_CONTROL[CTL_PULSE_MODE_POS];
            pulse_width_field_q <= RST_CLOCK_SEL[CLK_WIDTH_LSB +: 3];
            clock_source_field_q <= RST_CLOCK_SEL[CLK_SOURCE_LSB +: 3];
            step_value_q <= RST_STEP;
        end
        else if (wr_go && w_lane_q)
        begin
            case (wr_addr)
                OFF_CONTROL:
                begin
                    module_enable_bit_q <= wr_byte[CTL_ENABLE_POS];
                    output_invert_bit_q <= wr_byte[CTL_INVERT_POS];
                    pulse_mode_select_bit_q <= wr_byte[CTL_PULSE_MODE_POS];
                end
                OFF_CLOCK_SEL:
                begin
                    pulse_width_field_q <= wr_byte[CLK_WIDTH_LSB +: 3];
                    clock_source_field_q <= wr_byte[CLK_SOURCE_LSB +: 3];
                end
                OFF_STEP_LOW: step_value_q[7:0] <= wr_byte;
                OFF_STEP_HIGH: step_value_q[15:8] <= wr_byte;
                OFF_STEP_UPPER: step_value_q[19:16] <= wr_byte[3:0];
                default:
                begin
                end
            endcase
        end
    end

    // ************************************************************
    // input clock selection and edges
    // ************************************************************
    assign src_raw = {clk_src_cell, clk_src_fast, clk_src_system};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++)
        begin : g_sync
            nco_sync u_sync
            (
                .clk(mclk),
                .rst_n(rst_n),
                .async_in(src_raw[gi]),
                .sync_out(src_sync[gi])
            );
        end
    endgenerate

    // reserved codes select no clock
    always_comb
    begin
        if (clock_source_field_q <= SRC_CELL_LAST)
        begin
            sel_clk = src_sync[clock_source_field_q];
        end
        else
        begin
            sel_clk = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_clk_prev_q <= 1'b0;
        end
        else
        begin
            sel_clk_prev_q <= sel_clk;
        end
    end

    assign clk_rise = sel_clk && !sel_clk_prev_q;
    assign clk_fall = !sel_clk && sel_clk_prev_q;

    // ************************************************************
    // accumulator and working buffer
    // ************************************************************
    assign acc_sum = {1'b0, phase_accumulator_q} + {1'b0, step_working_buffer_q};
    assign acc_overflow = module_enable_bit_q && clk_rise && acc_sum[ACC_W];
    assign acc_wr = wr_go && w_lane_q
        && (wr_addr == OFF_ACC_LOW || wr_addr == OFF_ACC_HIGH || wr_addr == OFF_ACC_UPPER);

    // sum advances on selected clock rises while enabled; bus writes win over the adder
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_accumulator_q <= RST_ACC;
        end
        else if (acc_wr)
        begin
            case (wr_addr)
                OFF_ACC_LOW: phase_accumulator_q[7:0] <= wr_byte;
                OFF_ACC_HIGH: phase_accumulator_q[15:8] <= wr_byte;
                default: phase_accumulator_q[19:16] <= wr_byte[3:0];
            endcase
        end
        else if (module_enable_bit_q && clk_rise)
        begin
            phase_accumulator_q <= acc_sum[ACC_W-1:0];
        end
    end

    // buffer transfer on the falling edge, or at once while disabled
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            step_working_buffer_q <= RST_STEP;
            step_load_pend_q <= 1'b0;
        end
        else
        begin
            if (step_load_pend_q && (clk_fall || !module_enable_bit_q))
            begin
                step_working_buffer_q <= step_value_q;
            end
            if (wr_go && w_lane_q && (wr_addr == OFF_STEP_LOW
                || (!module_enable_bit_q && (wr_addr == OFF_STEP_HIGH
                || wr_addr == OFF_STEP_UPPER))))
            begin
                step_load_pend_q <= 1'b1; // new write keeps the request
            end
            else if (clk_fall || !module_enable_bit_q)
            begin
                step_load_pend_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // output shaping
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            toggle_level_q <= 1'b0;
            pulse_pend_q <= 1'b0;
            pulse_active_q <= 1'b0;
            pulse_left_q <= 8'h00;
        end
        else if (!module_enable_bit_q)
        begin
            pulse_pend_q <= 1'b0;
            pulse_active_q <= 1'b0;
        end
        else if (clk_rise)
        begin
            if (acc_overflow && !pulse_mode_select_bit_q)
            begin
                toggle_level_q <= !toggle_level_q;
            end
            pulse_pend_q <= acc_overflow && pulse_mode_select_bit_q;
            if (pulse_pend_q)
            begin
                pulse_active_q <= 1'b1;
                pulse_left_q <= 8'h01 << pulse_width_field_q;
            end
            else if (pulse_active_q)
            begin
                pulse_active_q <= (pulse_left_q != 8'h01);
                pulse_left_q <= pulse_left_q - 8'h01;
            end
        end
    end

    assign raw_level = pulse_mode_select_bit_q ? pulse_active_q : toggle_level_q;

    // polarity stage and sticky overflow flag
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_out <= 1'b0;
            overflow_flag <= 1'b0;
        end
        else
        begin
            osc_out <= raw_level ^ output_invert_bit_q;
            if (acc_overflow)
            begin
                overflow_flag <= 1'b1;
            end
            else if (wr_go && w_lane_q && wr_addr == OFF_STATUS && wr_byte[STAT_FLAG_POS])
            begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    always_comb
    begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        case (s_axi_araddr)
            OFF_CONTROL:
            begin
                rd_byte[CTL_ENABLE_POS] = module_enable_bit_q;
                rd_byte[CTL_LEVEL_POS] = osc_out;
                rd_byte[CTL_INVERT_POS] = output_invert_bit_q;
                rd_byte[CTL_PULSE_MODE_POS] = pulse_mode_select_bit_q;
            end
            OFF_CLOCK_SEL:
            begin
                rd_byte[CLK_WIDTH_LSB +: 3] = pulse_width_field_q;
                rd_byte[CLK_SOURCE_LSB +: 3] = clock_source_field_q;
            end
            OFF_ACC_LOW: rd_byte = phase_accumulator_q[7:0];
            OFF_ACC_HIGH: rd_byte = phase_accumulator_q[15:8];
            OFF_ACC_UPPER: rd_byte = {4'h0, phase_accumulator_q[19:16]};
            OFF_STEP_LOW: rd_byte = step_value_q[7:0];
            OFF_STEP_HIGH: rd_byte = step_value_q[15:8];
            OFF_STEP_UPPER: rd_byte = {4'h0, step_value_q[19:16]};
            OFF_STATUS: rd_byte[STAT_FLAG_POS] = overflow_flag;
            default: rd_hit = 1'b0;
        endcase
    end

    // one read in flight; data held until taken
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_hold_disabled;
        @(posedge mclk) disable iff (!rst_n)
        (!module_enable_bit_q && !acc_wr) |=> $stable(phase_accumulator_q);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled) else $error("acc moved while off");

    property p_add;
        @(posedge mclk) disable iff (!rst_n)
        (module_enable_bit_q && clk_rise && !acc_wr)
            |=> phase_accumulator_q == 20'($past(phase_accumulator_q) + $past(step_working_buffer_q));
    endproperty
    a_add: assert property (p_add) else $error("accumulator sum wrong");

    property p_flag;
        @(posedge mclk) disable iff (!rst_n)
        acc_overflow |=> overflow_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("overflow flag not set");

    property p_toggle;
        @(posedge mclk) disable iff (!rst_n)
        (acc_overflow && !pulse_mode_select_bit_q) |=> toggle_level_q != $past(toggle_level_q);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle on overflow");

    property p_level_read;
        @(posedge mclk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_CONTROL)
            |=> s_axi_rdata[CTL_LEVEL_POS] == $past(osc_out);
    endproperty
    a_level_read: assert property (p_level_read) else $error("level bit wrong");

    property p_unimpl;
        @(posedge mclk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_CONTROL)
            |=> s_axi_rdata[6] == 1'b0 && s_axi_rdata[3:1] == 3'h0 && s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unused bits not zero");

    property p_polarity;
        @(posedge mclk) disable iff (!rst_n)
        1'b1 |=> osc_out == ($past(raw_level) ^ $past(output_invert_bit_q));
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity wrong");

    property p_buf_load;
        @(posedge mclk) disable iff (!rst_n)
        (step_load_pend_q && (clk_fall || !module_enable_bit_q))
            |=> step_working_buffer_q == $past(step_value_q);
    endproperty
    a_buf_load: assert property (p_buf_load) else $error("buffer not loaded");

    property p_pulse_start;
        @(posedge mclk) disable iff (!rst_n)
        (module_enable_bit_q && clk_rise && pulse_pend_q)
            |=> pulse_active_q && pulse_left_q == (8'h01 << $past(pulse_width_field_q));
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse start wrong");
endmodule

/* File: tb_nco_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module tb_nco_top
    import nco_pkg::*;
;
    logic mclk = 0;
    logic rst_n = 0;
    logic [5:0] awaddr = 0;
    logic [5:0] araddr = 0;
    logic [31:0] wdata = 0;
    logic [31:0] rdata;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic awvalid = 0;
    logic wvalid = 0;
    logic bready = 0;
    logic arvalid = 0;
    logic rready = 0;
    logic awready, wready, bvalid, arready, rvalid, osc_out, flag;
    logic [5:0] src = 0;
    logic [7:0] rd;
    logic [1:0] rs;
    logic [1:0] ws;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;

    nco_top u_nco_top (
        .mclk(mclk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .clk_src_system(src[0]), .clk_src_fast(src[1]), .clk_src_cell(src[5:2]),
        .osc_out(osc_out), .overflow_flag(flag)
    );

    // ************************************************************
    // clock, hang guard, bus tasks
    // ************************************************************
    always #2 mclk = ~mclk;

    // cut a hang short
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fail_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // write one byte register, address and data offered together
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic aw_done;
        logic w_done;
        @(posedge mclk);
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel released at the edge its ready is seen high
        while (!(aw_done && w_done))
        begin
            @(posedge mclk);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1)
            @(posedge mclk);
        ws = bresp;
        bready <= 1'b0;
    endtask

    // read one byte register
    task automatic rdr(input logic [5:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        rd = rdata[7:0];
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic ck(input logic [5:0] a, input logic [7:0] e);
        rdr(a);
        `CHK("rdata", e, rd)
    endtask

    // one rising edge on the chosen source pins
    task automatic rise(input logic [5:0] m);
        src <= m;
        repeat (6) @(posedge mclk);
        src <= 6'h00;
        repeat (6) @(posedge mclk);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic sc_reset();
        ck(OFF_CONTROL, 8'h00);
        ck(OFF_CLOCK_SEL, 8'h00);
        ck(OFF_ACC_LOW, 8'h00);
        ck(OFF_ACC_HIGH, 8'h00);
        ck(OFF_ACC_UPPER, 8'h00);
        ck(OFF_STEP_LOW, 8'h01);
        ck(OFF_STEP_HIGH, 8'h00);
        ck(OFF_STEP_UPPER, 8'h00);
    endtask

    task automatic sc_regs();
        wr(OFF_CONTROL, 8'h5F);
        ck(OFF_CONTROL, 8'h31);
        `CHK("osc_out", 1'b1, osc_out)
        wr(OFF_CONTROL, 8'h00);
        ck(OFF_CONTROL, 8'h00);
        `CHK("osc_out", 1'b0, osc_out)
        wr(OFF_CLOCK_SEL, 8'hFF);
        ck(OFF_CLOCK_SEL, 8'hE7);
        wr(OFF_ACC_UPPER, 8'hFF);
        ck(OFF_ACC_UPPER, 8'h0F);
        wr(OFF_ACC_LOW, 8'hA5);
        ck(OFF_ACC_LOW, 8'hA5);
        wr(OFF_STEP_UPPER, 8'hFF);
        ck(OFF_STEP_UPPER, 8'h0F);
        wr(OFF_STEP_HIGH, 8'h5A);
        ck(OFF_STEP_HIGH, 8'h5A);
        wr(6'h24, 8'h01);
        `CHK("bresp", RESP_SLVERR, ws)
        rdr(6'h24);
        `CHK("rresp", RESP_SLVERR, rs)
    endtask

    task automatic sc_toggle();
        wr(OFF_CLOCK_SEL, 8'h00);
        wr(OFF_ACC_LOW, 8'h00);
        wr(OFF_ACC_UPPER, 8'h00);
        wr(OFF_STEP_UPPER, 8'h08);
        wr(OFF_STEP_HIGH, 8'h00);
        wr(OFF_STEP_LOW, 8'h00);
        rise(6'h01);
        ck(OFF_ACC_UPPER, 8'h00);
        wr(OFF_CONTROL, 8'h80);
        rise(6'h01);
        ck(OFF_ACC_UPPER, 8'h08);
        rise(6'h01);
        ck(OFF_ACC_UPPER, 8'h00);
        `CHK("flag", 1'b1, flag)
        `CHK("osc_out", 1'b1, osc_out)
        ck(OFF_CONTROL, 8'hA0);
        wr(OFF_STATUS, 8'h01);
        @(posedge mclk);
        `CHK("flag", 1'b0, flag)
        rise(6'h01);
        rise(6'h01);
        `CHK("osc_out", 1'b0, osc_out)
        `CHK("flag", 1'b1, flag)
        wr(OFF_STATUS, 8'h01);
    endtask

    // sources 1 to 5 count only when chosen; reserved code 6 counts none
    task automatic sc_sources();
        for (int c = 1; c < 6; c++)
        begin
            wr(OFF_CLOCK_SEL, 8'(c));
            rise(~(6'h01 << c));
            rise(6'h01 << c);
            ck(OFF_ACC_UPPER, (c % 2) ? 8'h08 : 8'h00);
        end
        wr(OFF_CLOCK_SEL, 8'h06);
        rise(6'h3F);
        ck(OFF_ACC_UPPER, 8'h08);
    endtask

    task automatic sc_pulse();
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_ACC_UPPER, 8'h08);
        wr(OFF_STEP_UPPER, 8'h04);
        wr(OFF_CLOCK_SEL, 8'h20);
        wr(OFF_CONTROL, 8'h81);
        rise(6'h01);
        rise(6'h01);
        `CHK("osc_out", 1'b0, osc_out)
        rise(6'h01);
        `CHK("osc_out", 1'b1, osc_out)
        ck(OFF_CONTROL, 8'hA1);
        rise(6'h01);
        `CHK("osc_out", 1'b1, osc_out)
        rise(6'h01);
        `CHK("osc_out", 1'b0, osc_out)
        // low step write while running waits for the input clock fall
        wr(OFF_STEP_UPPER, 8'h00);
        wr(OFF_STEP_LOW, 8'h01);
        rise(6'h01);
        ck(OFF_ACC_UPPER, 8'h00);
        rise(6'h01);
        ck(OFF_ACC_LOW, 8'h01);
    endtask

    // main sequence
    initial
    begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        sc_reset();
        sc_regs();
        sc_toggle();
        sc_sources();
        sc_pulse();
        stop_test();
    end
endmodule
